/* common/gtc_pkg.sv */
// Behaviour
// [RULE1] 16-bit counter readable as two bytes
// [RULE2] Byte write loads that counter byte at once
// [RULE3] Source select: 0 instruction clock, 1 pin
// [RULE4] Internal source advances per prescaled instruction cycle
// [RULE5] Pin source counts rising edges, optionally synchronised
// [RULE6] Falling edge needed before first counted rise
// [RULE7] Prescale field divides by 1, 2, 4, 8
// [RULE8] Prescaler hidden, cleared on counter byte write
// [RULE9] Oscillator enable starts crystal, runs in sleep
// [RULE10] Crystal usable only with internal or low-power clock
// [RULE11] Crystal pins read data 0, direction 1
// [RULE12] Software waits oscillator start-up before enabling timer
// [RULE13] Sync disable bypasses phases, counts during sleep
// [RULE14] Sync mode switch may drop or add one
// [RULE15] Counter byte reads always valid
// [RULE16] Software stops counter before writing it
// [RULE17] Gate source: gate pin or second comparator
// [RULE18] Gate acts only with gate enable set
// [RULE19] Invert bit inverts selected gate source
// [RULE20] Wrap FFFF to 0000 sets overflow flag
// [RULE21] Request needs three enables; flag sticky
// [RULE22] Async overflow in sleep wakes device
// [RULE23] Invert set counts gate high, else low
// [RULE24] Gate enable follows gate; timer off ignores it
// [RULE25] Internal source ignores sync disable
// [RULE26] Prescale code n divides by two to n
// [RULE27] Timer off holds counter, prescaler, flag
package gtc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int CNT_W = 16;
   localparam logic [ADDR_W-1:0] TIMER_CONTROL_REG = 3'h0;
   localparam logic [ADDR_W-1:0] COUNT_LOW_BYTE = 3'h1;
   localparam logic [ADDR_W-1:0] COUNT_HIGH_BYTE = 3'h2;
   localparam logic [ADDR_W-1:0] PERIPHERAL_FLAG_REG = 3'h3;
   localparam logic [ADDR_W-1:0] PERIPHERAL_ENABLE_REG = 3'h4;
   localparam logic [ADDR_W-1:0] INTERRUPT_CONTROL_REG = 3'h5;
   localparam logic [ADDR_W-1:0] COMPARATOR_CONFIG_REG = 3'h6;
   localparam logic [ADDR_W-1:0] OSC_PIN_REG = 3'h7;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTL_TIMER_ON = 0;
   localparam int CTL_CLOCK_SOURCE_SELECT = 1;
   localparam int CTL_SYNC_DISABLE = 2;
   localparam int CTL_CRYSTAL_OSC_ENABLE = 3;
   localparam int CTL_PS_LO = 4;
   localparam int CTL_PS_HI = 5;
   localparam int CTL_GATE_ENABLE = 6;
   localparam int CTL_GATE_INVERT = 7;
   localparam int FLAG_OVERFLOW = 0;
   localparam int EN_OVERFLOW_IRQ = 0;
   localparam int ICR_PERIPHERAL_IRQ_ENABLE = 6;
   localparam int ICR_GLOBAL_IRQ_ENABLE = 7;
   localparam int CMP_GATE_SOURCE = 1;
   localparam int PIN_DATA_LO = 0;
   localparam int PIN_DIR_LO = 2;
   // ----------------------------------------
   // Reset values and counts
   // ----------------------------------------
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam logic [1:0] PIN_ONES = 2'h3;
   localparam logic [1:0] PIN_ZEROS = 2'h0;
   localparam logic [2:0] PS_ZERO = 3'h0;

   // Last prescaler count for code n, ratio two to n
   function automatic logic [2:0] ps_last(input logic [1:0] sel);
      ps_last = 3'((4'h1 << sel) - 4'h1);
   endfunction
endpackage

/* core/gtc_sync2.sv */
`timescale 1ns/1ns
module gtc_sync2
   import gtc_pkg::*;
#(
   parameter int W = 1
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   // Meta stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_q <= '0;
         q_o <= '0;
      end
      else
      begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule

/* core/gtc_prescaler.sv */
`timescale 1ns/1ns
module gtc_prescaler
   import gtc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic clr_i,
   input wire logic tick_i,
   input wire logic [1:0] sel_i,
   // Divided tick
   output logic tick_o
);
   logic [2:0] cnt_q;

   assign tick_o = tick_i && !clr_i && (cnt_q >= ps_last(sel_i)); // RULE7 RULE26

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cnt_q <= PS_ZERO;
      else if (clr_i || tick_o)
         cnt_q <= PS_ZERO; // RULE8
      else if (tick_i)
         cnt_q <= cnt_q + 3'h1;
   end

   pre_clr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
      clr_i |=> cnt_q == PS_ZERO)
      else $error("prescaler not cleared");
   pre_ratio_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
      tick_o |-> cnt_q == ps_last(sel_i) || cnt_q > ps_last(sel_i))
      else $error("prescaler tick early");
endmodule

/* core/gtc_timer.sv */
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module gtc_timer
   import gtc_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   // Pins and comparator
   input wire logic ext_count_input_i,
   input wire logic gate_pin_i,
   input wire logic second_comparator_i,
   input wire logic [1:0] osc_pin_data_i,
   input wire logic [1:0] osc_pin_dir_i,
   // System status
   input wire logic sleep_i,
   input wire logic lp_clock_ok_i,
   // Outputs
   output logic irq_o,
   output logic wake_o,
   output logic osc_run_o,
   output logic osc_pin_dir_force_o
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_q;
   logic rst_q;

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_meta_q <= 1'b0;
         rst_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_q <= rst_meta_q;
      end
   end

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [6:0] pins_s;
   logic ext_s;
   logic gate_s;
   logic cmp_s;
   logic [1:0] pdata_s;
   logic [1:0] pdir_s;

   gtc_sync2 #(.W(7)) u_sync (
      .clk_i(mclk_i),
      .rst_n_i(rst_q),
      .d_i({osc_pin_dir_i, osc_pin_data_i, second_comparator_i, gate_pin_i,
         ext_count_input_i}),
      .q_o(pins_s)
   );
   assign ext_s = pins_s[0];
   assign gate_s = pins_s[1];
   assign cmp_s = pins_s[2];
   assign pdata_s = pins_s[4:3];
   assign pdir_s = pins_s[6:5];

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   logic [DATA_W-1:0] ctl_q;
   logic overflow_irq_enable_q;
   logic peripheral_irq_enable_q;
   logic global_irq_enable_q;
   logic gate_source_q;
   logic wr_low;
   logic wr_high;
   logic wr_cnt;

   assign wr_low = wr_i && addr_i == COUNT_LOW_BYTE;
   assign wr_high = wr_i && addr_i == COUNT_HIGH_BYTE;
   assign wr_cnt = wr_low || wr_high;

   always_ff @(posedge mclk_i or negedge rst_q)
   begin
      if (!rst_q)
      begin
         ctl_q <= REG_RESET;
         overflow_irq_enable_q <= 1'b0;
         peripheral_irq_enable_q <= 1'b0;
         global_irq_enable_q <= 1'b0;
         gate_source_q <= 1'b0;
      end
      else if (wr_i)
      begin
         unique case (addr_i)
            TIMER_CONTROL_REG: ctl_q <= wdata_i;
            PERIPHERAL_ENABLE_REG: overflow_irq_enable_q <= wdata_i[EN_OVERFLOW_IRQ];
            INTERRUPT_CONTROL_REG:
            begin
               peripheral_irq_enable_q <= wdata_i[ICR_PERIPHERAL_IRQ_ENABLE];
               global_irq_enable_q <= wdata_i[ICR_GLOBAL_IRQ_ENABLE];
            end
            COMPARATOR_CONFIG_REG: gate_source_q <= wdata_i[CMP_GATE_SOURCE];
            default: ;
         endcase
      end
   end

   logic timer_on;
   logic clock_source_select;
   logic sync_disable;
   logic crystal_osc_enable;
   logic [1:0] prescale_select;
   logic gate_enable;
   logic gate_invert;

   assign timer_on = ctl_q[CTL_TIMER_ON];
   assign clock_source_select = ctl_q[CTL_CLOCK_SOURCE_SELECT];
   assign sync_disable = ctl_q[CTL_SYNC_DISABLE];
   assign crystal_osc_enable = ctl_q[CTL_CRYSTAL_OSC_ENABLE];
   assign prescale_select = ctl_q[CTL_PS_HI:CTL_PS_LO];
   assign gate_enable = ctl_q[CTL_GATE_ENABLE];
   assign gate_invert = ctl_q[CTL_GATE_INVERT];

   // ----------------------------------------
   // Instruction phase and pin edges
   // ----------------------------------------
   logic [1:0] phase_q;
   logic inst_tick;
   logic ext_d_q;
   logic rise;
   logic fall;

   // Oscillator over four; stopped in sleep like the core clock
   always_ff @(posedge mclk_i or negedge rst_q)
   begin
      if (!rst_q)
         phase_q <= 2'h0;
      else if (!sleep_i)
         phase_q <= phase_q + 2'h1;
   end
   assign inst_tick = phase_q == PHASE_LAST && !sleep_i;

   always_ff @(posedge mclk_i or negedge rst_q)
   begin
      if (!rst_q)
         ext_d_q <= 1'b0;
      else
         ext_d_q <= ext_s;
   end
   assign rise = ext_s && !ext_d_q;
   assign fall = !ext_s && ext_d_q;

   // ----------------------------------------
   // First-edge arming
   // ----------------------------------------
   logic need_fall_q;
   logic on_d_q;
   logic hi_at_off_q;

   // Reset value covers enabling after power-on
   always_ff @(posedge mclk_i or negedge rst_q)
   begin
      if (!rst_q)
         need_fall_q <= 1'b1;
      else if (wr_cnt)
         need_fall_q <= 1'b1; // RULE6
      else if (timer_on && !on_d_q && hi_at_off_q && !ext_s)
         need_fall_q <= 1'b1; // RULE6
      else if (fall)
         need_fall_q <= 1'b0; // RULE6
   end

   always_ff @(posedge mclk_i or negedge rst_q)
   begin
      if (!rst_q)
      begin
         on_d_q <= 1'b0;
         hi_at_off_q <= 1'b0;
      end
      else
      begin
         on_d_q <= timer_on;
         if (on_d_q && !timer_on)
            hi_at_off_q <= ext_s;
      end
   end

   // ----------------------------------------
   // Source select and gate
   // ----------------------------------------
   logic rise_ok;
   logic pend_q;
   logic src_tick;
   logic gate_sel;
   logic count_en;
   logic pre_out;

   assign rise_ok = rise && !need_fall_q; // RULE6

   // Synchronous mode holds an edge until the next instruction boundary
   always_ff @(posedge mclk_i or negedge rst_q)
   begin
      if (!rst_q)
         pend_q <= 1'b0;
      else if (wr_cnt || sync_disable)
         pend_q <= 1'b0; // RULE14
      else if (rise_ok)
         pend_q <= 1'b1;
      else if (inst_tick)
         pend_q <= 1'b0;
   end

   always_comb
   begin
      if (!clock_source_select)
         src_tick = inst_tick; // RULE3 RULE4 RULE25
      else if (sync_disable)
         src_tick = rise_ok; // RULE5 RULE13
      else
         src_tick = pend_q && inst_tick; // RULE5
   end

   assign gate_sel = gate_source_q ? cmp_s : gate_s; // RULE17
   assign count_en = timer_on && (!gate_enable || gate_sel == gate_invert); // RULE18 RULE19 RULE23 RULE24 RULE27

   gtc_prescaler u_pre (
      .clk_i(mclk_i),
      .rst_n_i(rst_q),
      .clr_i(wr_cnt),
      .tick_i(src_tick && count_en),
      .sel_i(prescale_select),
      .tick_o(pre_out)
   );

   // ----------------------------------------
   // Counter and overflow
   // ----------------------------------------
   logic [CNT_W-1:0] cnt_q;
   logic overflow_flag_q;
   logic ovf;

   assign ovf = pre_out && cnt_q == CNT_MAX;

   // Write beats increment; software is expected to stop first
   always_ff @(posedge mclk_i or negedge rst_q)
   begin
      if (!rst_q)
         cnt_q <= CNT_RESET;
      else if (wr_low)
         cnt_q[DATA_W-1:0] <= wdata_i; // RULE2 RULE16
      else if (wr_high)
         cnt_q[CNT_W-1:DATA_W] <= wdata_i; // RULE2 RULE16
      else if (pre_out)
         cnt_q <= cnt_q + 16'h0001; // RULE1
   end

   // Set wins over a same-cycle software clear
   always_ff @(posedge mclk_i or negedge rst_q)
   begin
      if (!rst_q)
         overflow_flag_q <= 1'b0;
      else if (ovf)
         overflow_flag_q <= 1'b1; // RULE20
      else if (wr_i && addr_i == PERIPHERAL_FLAG_REG)
         overflow_flag_q <= wdata_i[FLAG_OVERFLOW]; // RULE21
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge rst_q)
   begin
      if (!rst_q)
      begin
         irq_o <= 1'b0;
         wake_o <= 1'b0;
         osc_run_o <= 1'b0;
         osc_pin_dir_force_o <= 1'b0;
      end
      else
      begin
         irq_o <= overflow_flag_q && overflow_irq_enable_q && peripheral_irq_enable_q
            && global_irq_enable_q; // RULE21
         wake_o <= sleep_i && timer_on && clock_source_select && sync_disable
            && overflow_flag_q && overflow_irq_enable_q && peripheral_irq_enable_q; // RULE22
         osc_run_o <= crystal_osc_enable && lp_clock_ok_i; // RULE9 RULE10
         osc_pin_dir_force_o <= crystal_osc_enable; // RULE11
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge rst_q)
   begin
      if (!rst_q)
         rdata_o <= REG_RESET;
      else if (!rd_i)
         rdata_o <= REG_RESET;
      else
      begin
         rdata_o <= REG_RESET;
         unique case (addr_i)
            TIMER_CONTROL_REG: rdata_o <= ctl_q;
            COUNT_LOW_BYTE: rdata_o <= cnt_q[DATA_W-1:0]; // RULE1 RULE15
            COUNT_HIGH_BYTE: rdata_o <= cnt_q[CNT_W-1:DATA_W]; // RULE1 RULE15
            PERIPHERAL_FLAG_REG: rdata_o[FLAG_OVERFLOW] <= overflow_flag_q;
            PERIPHERAL_ENABLE_REG: rdata_o[EN_OVERFLOW_IRQ] <= overflow_irq_enable_q;
            INTERRUPT_CONTROL_REG:
            begin
               rdata_o[ICR_PERIPHERAL_IRQ_ENABLE] <= peripheral_irq_enable_q;
               rdata_o[ICR_GLOBAL_IRQ_ENABLE] <= global_irq_enable_q;
            end
            COMPARATOR_CONFIG_REG: rdata_o[CMP_GATE_SOURCE] <= gate_source_q;
            OSC_PIN_REG:
            begin
               rdata_o[PIN_DATA_LO+1:PIN_DATA_LO] <= crystal_osc_enable ? PIN_ZEROS : pdata_s; // RULE11
               rdata_o[PIN_DIR_LO+1:PIN_DIR_LO] <= crystal_osc_enable ? PIN_ONES : pdir_s; // RULE11
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_q);

   sequence s_count_write;
      wr_i && (addr_i == COUNT_LOW_BYTE || addr_i == COUNT_HIGH_BYTE);
   endsequence
   sequence s_armed_hold;
      need_fall_q && !rise_ok;
   endsequence

   low_load_a: assert property (wr_low |=> cnt_q[DATA_W-1:0] == $past(wdata_i)) // RULE2
      else $error("low byte not loaded");
   high_load_a: assert property (wr_high |=> cnt_q[CNT_W-1:DATA_W] == $past(wdata_i)) // RULE2
      else $error("high byte not loaded");
   arm_write_a: assert property (s_count_write |=> s_armed_hold) // RULE6
      else $error("rise counted before falling edge");
   ovf_flag_a: assert property (ovf |=> overflow_flag_q && cnt_q == CNT_RESET) // RULE20
      else $error("wrap did not set flag");
   irq_gate_a: assert property (irq_o |-> $past(overflow_flag_q) && $past(global_irq_enable_q)
      && $past(peripheral_irq_enable_q) && $past(overflow_irq_enable_q)) // RULE21
      else $error("request without all enables");
   off_hold_a: assert property (!timer_on && !wr_cnt |=> $stable(cnt_q)) // RULE27
      else $error("counter moved while off");
   gate_block_a: assert property (timer_on && gate_enable && gate_sel != gate_invert
      && !wr_cnt |=> $stable(cnt_q)) // RULE24
      else $error("counted with gate closed");
   int_phase_a: assert property (!clock_source_select && pre_out |-> phase_q == PHASE_LAST) // RULE4
      else $error("internal count off phase");
   osc_pins_a: assert property (rd_i && addr_i == OSC_PIN_REG && crystal_osc_enable
      |=> rdata_o[PIN_DIR_LO+1:PIN_DIR_LO] == PIN_ONES
      && rdata_o[PIN_DATA_LO+1:PIN_DATA_LO] == PIN_ZEROS) // RULE11
      else $error("crystal pins read wrong");
   sleep_wake_a: assert property (sleep_i && ovf && timer_on && sync_disable
      && clock_source_select && overflow_irq_enable_q && peripheral_irq_enable_q
      ##1 sleep_i |=> wake_o) // RULE22
      else $error("overflow in sleep did not wake");
endmodule

/* bench/gtc_far_model.sv */
`timescale 1ns/1ns
module gtc_far_model
   import gtc_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Pins toward the timer
   output logic ext_o,
   output logic gate_o,
   output logic cmp_o
);
   // ----------------------------------------
   // Count pin and gate sources
   // ----------------------------------------
   initial
   begin
      ext_o = 1'b0;
      gate_o = 1'b0;
      cmp_o = 1'b0;
   end

   // Four cycles high and low, well above the two-cycle minimum
   task automatic pulse(input int n);
      repeat (n)
      begin
         repeat (4) @(posedge clk_i);
         ext_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         ext_o <= 1'b0;
      end
   endtask

   // Level hold, used to leave the pin high across a disable
   task automatic hold(input logic v);
      @(posedge clk_i);
      ext_o <= v;
   endtask

   task automatic levels(input logic g, input logic c);
      @(posedge clk_i);
      gate_o <= g;
      cmp_o <= c;
   endtask
endmodule

/* bench/gated_16bit_timer_counter_bench.sv */
`timescale 1ns/1ns
module gated_16bit_timer_counter_bench;
   import gtc_pkg::*;
   // ----------------------------------------
   // Wiring
   // ----------------------------------------
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic ext, gate, cmp, irq, wake, osc_run, dir_force;
   logic [1:0] pdat = 2'h0;
   logic [1:0] pdir = 2'h0;
   logic sleep = 1'b0;
   logic lpok = 1'b0;
   int bad_count = 0;
   int num_checks = 0;
   logic [15:0] c, c_hold;
   logic [7:0] r;

   always #5 mclk_i = ~mclk_i;

   gtc_far_model i_far (.clk_i(mclk_i), .ext_o(ext), .gate_o(gate), .cmp_o(cmp));

   gtc_timer i_dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .ext_count_input_i(ext),
      .gate_pin_i(gate), .second_comparator_i(cmp), .osc_pin_data_i(pdat),
      .osc_pin_dir_i(pdir), .sleep_i(sleep), .lp_clock_ok_i(lpok), .irq_o(irq),
      .wake_o(wake), .osc_run_o(osc_run), .osc_pin_dir_force_o(dir_force)
   );

   // ----------------------------------------
   // Bus and compare helpers
   // ----------------------------------------
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge mclk_i);
      wr_s <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge mclk_i);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rdc(output logic [15:0] v);
      logic [7:0] lo, hi;
      rd(COUNT_LOW_BYTE, lo);
      rd(COUNT_HIGH_BYTE, hi);
      v = {hi, lo};
   endtask

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Prescaler phase is not visible, so one count either way is allowed
   task automatic check_near(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      logic [15:0] s;
      s = ((seen - exp) == 16'h0001 || (exp - seen) == 16'h0001) ? exp : seen;
      check(nm, s, exp);
   endtask

   // Counter is loaded only while stopped, avoiding write contention
   task automatic run(input logic [7:0] ctl, input logic [15:0] st, input int np,
                      input int cyc, output logic [15:0] v);
      wr(COUNT_LOW_BYTE, st[7:0]);
      wr(COUNT_HIGH_BYTE, st[15:8]);
      wr(TIMER_CONTROL_REG, ctl);
      i_far.pulse(np);
      repeat (cyc) @(posedge mclk_i);
      wr(TIMER_CONTROL_REG, ctl & 8'hFE);
      rdc(v);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset_bytes();
      rd(TIMER_CONTROL_REG, r);
      check("control", 16'(r), 16'h0000);
      rdc(c);
      check("count", c, 16'h0000);
      wr(COUNT_LOW_BYTE, 8'hA5);
      wr(COUNT_HIGH_BYTE, 8'h5A);
      rdc(c);
      check("count load", c, 16'h5AA5);
      pdat <= 2'h2;
      pdir <= 2'h1;
      wr(OSC_PIN_REG, 8'hFF);
      repeat (4) @(posedge mclk_i);
      rd(OSC_PIN_REG, r);
      check("pin readback", 16'(r), 16'h0006);
   endtask

   task automatic t_prescale();
      for (int p = 0; p < 4; p++)
      begin
         run(8'h01 | 8'(p << 4), 16'h0000, 0, 64, c);
         check_near("internal count", c, 16'(64 >> (p + 2)));
      end
      run(8'h05, 16'h0000, 0, 64, c);
      check_near("sync ignored", c, 16'h0010);
      repeat (20) @(posedge mclk_i);
      rdc(c_hold);
      check("held when off", c_hold, c);
   endtask

   task automatic t_overflow();
      run(8'h01, 16'hFFFE, 0, 12, c);
      rd(PERIPHERAL_FLAG_REG, r);
      check("overflow flag", 16'(r), 16'h0001);
      check("irq masked", 16'(irq), 16'h0000);
      wr(PERIPHERAL_ENABLE_REG, 8'h01);
      wr(INTERRUPT_CONTROL_REG, 8'hC0);
      repeat (2) @(posedge mclk_i);
      check("irq on", 16'(irq), 16'h0001);
      wr(INTERRUPT_CONTROL_REG, 8'h40);
      repeat (2) @(posedge mclk_i);
      check("irq global off", 16'(irq), 16'h0000);
      wr(PERIPHERAL_FLAG_REG, 8'h00);
      rd(PERIPHERAL_FLAG_REG, r);
      check("flag cleared", 16'(r), 16'h0000);
   endtask

   task automatic t_external();
      run(8'h03, 16'h0000, 4, 8, c);
      check("sync pin count", c, 16'h0003);
      run(8'h07, 16'h0000, 4, 8, c);
      check("async pin count", c, 16'h0003);
      sleep <= 1'b1;
      run(8'h03, 16'h0000, 3, 8, c);
      check("sync in sleep", c, 16'h0000);
      run(8'h07, 16'h0000, 3, 8, c);
      check("async in sleep", c, 16'h0002);
      sleep <= 1'b0;
      // Pin high at disable, low at re-enable: first rise must be skipped
      wr(COUNT_LOW_BYTE, 8'h00);
      wr(COUNT_HIGH_BYTE, 8'h00);
      wr(TIMER_CONTROL_REG, 8'h07);
      i_far.pulse(2);
      i_far.hold(1'b1);
      repeat (4) @(posedge mclk_i);
      wr(TIMER_CONTROL_REG, 8'h06);
      i_far.hold(1'b0);
      repeat (4) @(posedge mclk_i);
      wr(TIMER_CONTROL_REG, 8'h07);
      i_far.pulse(2);
      repeat (8) @(posedge mclk_i);
      wr(TIMER_CONTROL_REG, 8'h06);
      rdc(c);
      check("rearm on enable", c, 16'h0003);
   endtask

   task automatic t_gate();
      logic [7:0] ctl[5] = '{8'h41, 8'hC1, 8'hC1, 8'h41, 8'h01};
      logic [7:0] cfg[5] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h00};
      logic gl[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      logic cl[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      logic [15:0] e[5] = '{16'h0000, 16'h0010, 16'h0000, 16'h0010, 16'h0010};
      for (int i = 0; i < 5; i++)
      begin
         wr(COMPARATOR_CONFIG_REG, cfg[i]);
         i_far.levels(gl[i], cl[i]);
         repeat (4) @(posedge mclk_i);
         run(ctl[i], 16'h0000, 0, 64, c);
         if (e[i] == 16'h0000)
            check("gated count", c, e[i]);
         else
            check_near("gated count", c, e[i]);
      end
   endtask

   task automatic t_osc_wake();
      pdat <= 2'h3;
      pdir <= 2'h0;
      lpok <= 1'b1;
      wr(TIMER_CONTROL_REG, 8'h08);
      repeat (4) @(posedge mclk_i);
      check("osc run", 16'(osc_run), 16'h0001);
      check("dir force", 16'(dir_force), 16'h0001);
      rd(OSC_PIN_REG, r);
      check("crystal pins", 16'(r), 16'h000C);
      lpok <= 1'b0;
      repeat (3) @(posedge mclk_i);
      check("osc blocked", 16'(osc_run), 16'h0000);
      wr(COUNT_LOW_BYTE, 8'hFF);
      wr(COUNT_HIGH_BYTE, 8'hFF);
      wr(INTERRUPT_CONTROL_REG, 8'h40);
      sleep <= 1'b1;
      wr(TIMER_CONTROL_REG, 8'h0F);
      i_far.pulse(2);
      repeat (6) @(posedge mclk_i);
      check("wake", 16'(wake), 16'h0001);
      check("irq no global", 16'(irq), 16'h0000);
      sleep <= 1'b0;
      wr(TIMER_CONTROL_REG, 8'h00);
      rdc(c);
      check("wrapped count", c, 16'h0000);
   endtask

   // ----------------------------------------
   // Sequence and watchdog
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      t_reset_bytes();
      t_prescale();
      t_overflow();
      t_external();
      t_gate();
      t_osc_wake();
      final_report();
   end

   // Whole run needs about 1200 cycles; allow twenty-five times that
   initial
   begin
      #300000;
      bad_count++;
      final_report();
   end
endmodule
